// ==== hdl/coproc_shmem_map.svh ====
`ifndef COPROC_SHMEM_MAP_SVH
`define COPROC_SHMEM_MAP_SVH
`define CP_REG_BASE      16'h0200
`define CP_REG_MASK      16'hFFF0
`define HOST_REG_ADDR    16'hD5C0
`define CP_REG_RESET     8'h3F
`define HOST_REG_RESET   8'hCC
`define FLAG_BIT         7
`define CP_WIN_LOC_BIT   6
`define CP_HALF_BIT      5
`define CP_ONES_MASK     8'h1F
`define HOST_UPPER_BIT   5
`define HOST_LOWER_BIT   4
`define HOST_HALF_BIT    3
`define HOST_SWAP_BIT    1
`define HOST_RUN_BIT     0
`define HOST_ONES_MASK   8'h44
`define CP_CLK_DIV       8
`endif

// ==== hdl/coproc_shmem_pkg.sv ====
package coproc_shmem_pkg;
  typedef enum logic [1:0] {
    SRC_PRIVATE = 2'b00,
    SRC_SHARED  = 2'b01,
    SRC_REG     = 2'b10,
    SRC_NONE    = 2'b11
  } mem_src_t;
endpackage

// ==== hdl/coproc_clock_div.sv ====
`timescale 1ns/10ps
// one-cycle enables: host slot on the first cycle of each period, period end on its last cycle
module coproc_clock_div #(
  parameter int RATIO = 8
) (
  input  wire logic clk,
  input  wire logic sysRst,
  output logic      hostSlot,
  output logic      periodEnd
);
  initial begin
    if (RATIO < 2 || RATIO > 256) $error("ratio out of range");
  end
  logic [7:0] phaseReg;
  always_ff @(posedge clk) begin
    if (sysRst || phaseReg == 8'(RATIO - 1)) begin
      phaseReg <= 8'h00;
    end else begin
      phaseReg <= phaseReg + 8'h01;
    end
  end
  assign hostSlot  = (phaseReg == 8'h00);
  assign periodEnd = (phaseReg == 8'(RATIO - 1));
endmodule

// ==== hdl/coproc_shared_memory_ctrl.sv ====
`timescale 1ns/10ps
`include "coproc_shmem_map.svh"
// Operation
// - coprocessor register decoded at all of 0x0200-0x020F, one register behind them
// - cp bit6 window at C000 (0) or 4000 (1); bit5 half A/B
// - cp bits 0-4 read as ones, writes ignored
// - cp register loads 0x3F at reset; bits 6-5 reload while coprocessor held in reset, flag bit does not
// - one shared flag on bit 7 of both registers, inverted between sides
// - host bit5 enables A000-BFFF window, default disabled
// - host bit4 enables 8000-9FFF window, default off, independent of bit5
// - host bit3 selects 16K half of host bank, default half B
// - host bits 6 and 2 read as ones, writes ignored
// - host bit1 swaps 32K banks; 0 host bank A, coprocessor bank B
// - host bit0 low holds coprocessor in reset; high lets it run
// - host register loads 0xCC at reset
// - coprocessor stepped in 7 of every 8 cycles, host in the 8th; one 128K RAM multiplexed
// - 64K shared split into two 32K banks, each with two 16K halves
// - lower host window maps first 8K of half, upper window second 8K
// - flag written by one side is seen by the other at once
module coproc_shared_memory_ctrl #(
  parameter int CLK_RATIO = `CP_CLK_DIV
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // host bus, sampled in host slot
  input  wire logic        hostSel,
  input  wire logic        hostWe,
  input  wire logic [15:0] hostAddr,
  input  wire logic [7:0]  hostWrData,
  output logic [7:0]       hostRdData,
  output logic             hostCartHit,
  // coprocessor bus, one access per clock
  input  wire logic        cpSel,
  input  wire logic        cpWe,
  input  wire logic [15:0] cpAddr,
  input  wire logic [7:0]  cpWrData,
  output logic [7:0]       cpRdData,
  output logic             cpClkEn,
  output logic             cpResetHold,
  // 128K ram port
  output logic [16:0]      ramAddr,
  output logic             ramWe,
  output logic             ramRe,
  output logic [7:0]       ramWrData,
  input  wire logic [7:0]  ramRdData
);
  initial begin
    if (CLK_RATIO != 8) $error("coprocessor ratio must be eight");
  end

  logic hostSlot;
  coproc_clock_div #(.RATIO(CLK_RATIO)) divider (
    .clk      (clk),
    .sysRst   (sys_rst),
    .hostSlot (hostSlot),
    .periodEnd()
  );
  assign cpClkEn = ~cpResetHold & ~hostSlot;

  logic       sharedFlagReg;
  logic       windowLocationReg, coprocHalfSelectReg;
  logic       upperWindowEnableReg, lowerWindowEnableReg;
  logic       hostHalfSelectReg, bankExchangeReg, coprocRunReg;
  logic       bankExchangeLive;

  // reset images; each field takes its bit from these
  localparam logic [7:0] HOST_RST = `HOST_REG_RESET;
  localparam logic [7:0] CP_RST   = `CP_REG_RESET;

  function automatic logic cpRegHit(input logic [15:0] a);
    return (a & `CP_REG_MASK) == `CP_REG_BASE;
  endfunction

  wire hostRegWr = hostSlot && hostSel && hostWe && hostAddr == `HOST_REG_ADDR;
  wire cpRegWr   = !hostSlot && cpSel && cpWe && !cpResetHold && cpRegHit(cpAddr);

  assign cpResetHold = ~coprocRunReg;

  // host register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      upperWindowEnableReg <= HOST_RST[`HOST_UPPER_BIT];
      lowerWindowEnableReg <= HOST_RST[`HOST_LOWER_BIT];
      hostHalfSelectReg    <= HOST_RST[`HOST_HALF_BIT];
      bankExchangeReg      <= HOST_RST[`HOST_SWAP_BIT];
      coprocRunReg         <= HOST_RST[`HOST_RUN_BIT];
    end else if (hostRegWr) begin
      upperWindowEnableReg <= hostWrData[`HOST_UPPER_BIT];
      lowerWindowEnableReg <= hostWrData[`HOST_LOWER_BIT];
      hostHalfSelectReg    <= hostWrData[`HOST_HALF_BIT];
      bankExchangeReg      <= hostWrData[`HOST_SWAP_BIT];
      coprocRunReg         <= hostWrData[`HOST_RUN_BIT];
    end
  end

  // the coprocessor's bank follows a host write at once; that edge ends the host slot,
  // between two coprocessor accesses, so none is cut, and a swap made while releasing
  // reset is already in place for the first fetch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bankExchangeLive <= HOST_RST[`HOST_SWAP_BIT];
    end else if (hostRegWr) begin
      bankExchangeLive <= hostWrData[`HOST_SWAP_BIT];
    end
  end

  // coprocessor register
  always_ff @(posedge clk) begin
    if (sys_rst || cpResetHold) begin
      windowLocationReg   <= CP_RST[`CP_WIN_LOC_BIT];
      coprocHalfSelectReg <= CP_RST[`CP_HALF_BIT];
    end else if (cpRegWr) begin
      windowLocationReg   <= cpWrData[`CP_WIN_LOC_BIT];
      coprocHalfSelectReg <= cpWrData[`CP_HALF_BIT];
    end
  end

  // flag holds host-side sense; coprocessor writes inverted value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sharedFlagReg <= HOST_RST[`FLAG_BIT];
    end else if (hostRegWr) begin
      sharedFlagReg <= hostWrData[`FLAG_BIT];
    end else if (cpRegWr) begin
      sharedFlagReg <= ~cpWrData[`FLAG_BIT];
    end
  end

  // host-side decode: 8000-BFFF, bit13 picks the 8K section
  logic hostWinHit;
  logic [16:0] hostRamAddr;
  always_comb begin
    hostWinHit = hostAddr[15:14] == 2'b10 &&
                 (hostAddr[13] ? upperWindowEnableReg : lowerWindowEnableReg);
    // layout: bit16 shared, bit15 bank, bit14 half, bit13 section
    hostRamAddr = {1'b1, bankExchangeReg, hostHalfSelectReg, hostAddr[13:0]};
  end

  // coprocessor-side decode
  logic cpWinHit;
  logic [16:0] cpRamAddr;
  coproc_shmem_pkg::mem_src_t cpSrc;
  always_comb begin
    cpWinHit = windowLocationReg ? (cpAddr[15:14] == 2'b01)
                                 : (cpAddr[15:14] == 2'b11);
    if (cpRegHit(cpAddr)) begin
      cpSrc = coproc_shmem_pkg::SRC_REG;
    end else if (cpWinHit) begin
      cpSrc = coproc_shmem_pkg::SRC_SHARED;
    end else begin
      cpSrc = coproc_shmem_pkg::SRC_PRIVATE;
    end
    if (cpSrc == coproc_shmem_pkg::SRC_SHARED) begin
      cpRamAddr = {1'b1, ~bankExchangeLive, coprocHalfSelectReg, cpAddr[13:0]};
    end else begin
      cpRamAddr = {1'b0, cpAddr};
    end
  end

  wire [7:0] hostRegView = {sharedFlagReg, 1'b0, upperWindowEnableReg, lowerWindowEnableReg,
                            hostHalfSelectReg, 1'b0, bankExchangeReg, coprocRunReg}
                           | `HOST_ONES_MASK;
  wire [7:0] cpRegView = {~sharedFlagReg, windowLocationReg, coprocHalfSelectReg, 5'h00}
                         | `CP_ONES_MASK;

  // one ram multiplexed: host in its slot, coprocessor otherwise
  wire cpActive = !hostSlot && cpSel && !cpResetHold;
  always_comb begin
    ramAddr   = 17'h00000;
    ramWe     = 1'b0;
    ramRe     = 1'b0;
    ramWrData = 8'h00;
    if (hostSlot && hostSel && hostWinHit) begin
      ramAddr   = hostRamAddr;
      ramWe     = hostWe;
      ramRe     = ~hostWe;
      ramWrData = hostWrData;
    end else if (cpActive && cpSrc != coproc_shmem_pkg::SRC_REG) begin
      ramAddr   = cpRamAddr;
      ramWe     = cpWe;
      ramRe     = ~cpWe;
      ramWrData = cpWrData;
    end
  end

  // read data from flops; ram data valid at the cycle after the access
  logic hostRamPend, cpRamPend;
  logic [7:0] hostRegLatch, cpRegLatch;
  // ram bytes stand for one cycle only; the register view stands until the next access
  // host read path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hostRamPend  <= 1'b0;
      hostRegLatch <= 8'h00;
      hostCartHit  <= 1'b0;
    end else begin
      hostRamPend <= hostSlot && hostSel && !hostWe && hostWinHit;
      if (hostSlot && hostSel) begin
        hostRegLatch <= hostRegView;
        hostCartHit  <= hostWinHit || hostAddr == `HOST_REG_ADDR;
      end
    end
  end

  // coprocessor read path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpRamPend  <= 1'b0;
      cpRegLatch <= 8'h00;
    end else begin
      cpRamPend <= cpActive && !cpWe && cpSrc != coproc_shmem_pkg::SRC_REG;
      if (cpActive) begin
        cpRegLatch <= cpRegView;
      end
    end
  end
  assign hostRdData = hostRamPend ? ramRdData : hostRegLatch;
  assign cpRdData   = cpRamPend ? ramRdData : cpRegLatch;
endmodule

// ==== tb/coproc_shmem_asserts.sv ====
`timescale 1ns/10ps
module coproc_shmem_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // host bus
  input wire logic        hostSel,
  input wire logic        hostWe,
  input wire logic [15:0] hostAddr,
  input wire logic [7:0]  hostWrData,
  input wire logic [7:0]  hostRdData,
  // coprocessor bus and ram
  input wire logic        cpSel,
  input wire logic        cpWe,
  input wire logic [15:0] cpAddr,
  input wire logic [7:0]  cpRdData,
  input wire logic        cpClkEn,
  input wire logic        cpResetHold,
  input wire logic        ramWe
);
  logic [2:0] ph;
  wire hr = ph == 3'h0 && hostSel && hostAddr == 16'hD5C0;
  wire ca = cpClkEn && cpSel && cpAddr[15:4] == 12'h020;
  // phase counted from reset release, mirrors the slot schedule
  always_ff @(posedge clk) ph <= sys_rst ? 3'h0 : ph + 3'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  rst_hold_a: assert property ($fell(sys_rst) |-> cpResetHold)
    else $error("coprocessor not held after reset");
  en_phase_a: assert property (cpClkEn |-> ph != 3'h0 && !cpResetHold)
    else $error("coprocessor step outside its phases");
  en_run_a: assert property (!cpResetHold && ph != 3'h0 |-> cpClkEn)
    else $error("coprocessor step missing while running");
  run_ctl_a: assert property (hr && hostWe |=> cpResetHold == !$past(hostWrData[0]))
    else $error("run bit not followed");
  host_ones_a: assert property (hr && !hostWe |=> (hostRdData & 8'h44) == 8'h44)
    else $error("host reserved bits not ones");
  cp_ones_a: assert property (ca && !cpWe |=> cpRdData[4:0] == 5'h1F)
    else $error("coprocessor reserved bits not ones");
  reg_mask_a: assert property (ca && cpWe |-> !ramWe)
    else $error("register write reached ram");
  flag_cross_a: assert property (hr && hostWe ##1 ca && !cpWe
    |=> cpRdData[7] == !$past(hostWrData[7], 2))
    else $error("flag not inverted across sides");
endmodule
bind coproc_shared_memory_ctrl coproc_shmem_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
  .hostSel(hostSel), .hostWe(hostWe), .hostAddr(hostAddr), .hostWrData(hostWrData),
  .hostRdData(hostRdData), .cpSel(cpSel), .cpWe(cpWe), .cpAddr(cpAddr), .cpRdData(cpRdData),
  .cpClkEn(cpClkEn), .cpResetHold(cpResetHold), .ramWe(ramWe));

// ==== tb/ram_model.sv ====
`timescale 1ns/10ps
// each idle cycle inverts the last output byte, so stale data shows inverted on odd idle cycles and true on even ones
module ram_model (
  // clock
  input wire logic        clk,
  // ram port
  input wire logic [16:0] ramAddr,
  input wire logic        ramWe,
  input wire logic        ramRe,
  input wire logic [7:0]  ramWrData,
  output logic [7:0]      ramRdData = 8'h00
);
  logic [7:0] mem [0:17'h1FFFF];
  always @(posedge clk) begin
    if (ramWe) mem[ramAddr] <= ramWrData;
    ramRdData <= ramRe ? mem[ramAddr] : ~ramRdData;
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
  logic        clk = 0, sys_rst = 1, hostSel = 0, hostWe = 0, cpSel = 0, cpWe = 0;
  logic [15:0] hostAddr = 16'h0, cpAddr = 16'h0;
  logic [7:0]  hostWrData = 8'h0, cpWrData = 8'h0, hostRdData, cpRdData, ramWrData, ramRdData;
  logic        hostCartHit, cpClkEn, cpResetHold, ramWe, ramRe;
  logic [16:0] ramAddr;
  logic [2:0]  ph = 3'h0;
  logic [31:0] rnd = 32'hBF9EBC03;
  logic [9:0]  q[$];
  logic [7:0]  hostShadow = 8'hCC;
  int          n_fail = 0, samples_checked = 0, cyc = 0;
  event        resEv;
  always #12.5 clk = ~clk;
  always @(posedge clk) ph <= sys_rst ? 3'h0 : ph + 3'h1;
  coproc_shared_memory_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .hostSel(hostSel),
    .hostWe(hostWe), .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData),
    .hostCartHit(hostCartHit), .cpSel(cpSel), .cpWe(cpWe), .cpAddr(cpAddr),
    .cpWrData(cpWrData), .cpRdData(cpRdData), .cpClkEn(cpClkEn), .cpResetHold(cpResetHold),
    .ramAddr(ramAddr), .ramWe(ramWe), .ramRe(ramRe), .ramWrData(ramWrData),
    .ramRdData(ramRdData));
  ram_model u_ram (.clk(clk), .ramAddr(ramAddr), .ramWe(ramWe), .ramRe(ramRe),
    .ramWrData(ramWrData), .ramRdData(ramRdData));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task give_verdict;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task cmp(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cmp_hit(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t hit got=%h exp=%h", $time, g, e);
    end
  endtask
  // reads carry their expected byte in d; the monitor compares once data settles
  task hacc(input logic w, input logic [15:0] a, input logic [7:0] d);
    logic hitExp;
    while (ph != 3'h0) @(negedge clk);
    hitExp = a == 16'hD5C0 ||
             (a[15:14] == 2'b10 && (a[13] ? hostShadow[5] : hostShadow[4]));
    if (w && a == 16'hD5C0) hostShadow = d;
    {hostSel, hostWe, hostAddr, hostWrData} = {1'b1, w, a, d};
    @(negedge clk);
    hostSel = 0;
    q.push_back({2'b10, 7'h00, hitExp});
    if (!w) q.push_back({2'b00, d});
    ->resEv;
  endtask
  task cacc(input logic w, input logic [15:0] a, input logic [7:0] d);
    while (!cpClkEn) @(negedge clk);
    {cpSel, cpWe, cpAddr, cpWrData} = {1'b1, w, a, d};
    @(negedge clk);
    cpSel = 0;
    if (!w) begin q.push_back({2'b01, d}); ->resEv; end
    @(negedge clk);
  endtask
  always begin
    logic [9:0] n;
    @(resEv);
    while (q.size() > 0) begin
      n = q.pop_front();
      if (n[9]) cmp_hit(hostCartHit, n[0]);
      else cmp(n[8] ? cpRdData : hostRdData, n[7:0]);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin n_fail++; give_verdict(); end
  end
  initial begin
    repeat (8) @(negedge clk);
    sys_rst = 0;
    hacc(0, 16'hD5C0, 8'hCC);
    $display("test reset done");
    rnd = lfsr(rnd);
    hacc(1, 16'hD5C0, 8'hB8);
    hacc(1, 16'hA000, rnd[7:0]);
    hacc(1, 16'h8000, rnd[15:8]);
    hacc(0, 16'hA000, rnd[7:0]);
    hacc(0, 16'h8000, rnd[15:8]);
    hacc(1, 16'hD5C0, 8'hAB);
    hacc(1, 16'h8000, 8'h5A);
    cacc(0, 16'hE000, rnd[7:0]);
    cacc(0, 16'hC000, rnd[15:8]);
    $display("test swap done");
    cacc(0, 16'h0207, 8'h3F);
    cacc(1, 16'h020F, 8'hC0);
    cacc(0, 16'h0200, 8'hDF);
    hacc(0, 16'hD5C0, 8'h6F);
    hacc(1, 16'hD5C0, 8'hAA);
    hacc(1, 16'hD5C0, 8'hAB);
    cacc(0, 16'h0200, 8'h3F);
    $display("test flag done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      hacc(1, 16'hD5C0, rnd[7:0]);
      hacc(0, 16'hD5C0, rnd[7:0] | 8'h44);
    end
    $display("test reserved done");
    give_verdict();
  end
endmodule
